// file: core/scd_io_decode.sv
// Purpose: Full 16-bit fixed I/O address decode
// Assumes: Address stable during the cycle strobe
// Notes: Purely combinational, no aliasing
`timescale 1ns/1ps
module scd_io_decode (
  // Address
  input wire logic [15:0] addr,
  // Selects
  output logic sel_dma1,
  output logic sel_pic1,
  output logic sel_pcfg_idx,
  output logic sel_pcfg_dat,
  output logic sel_ccfg_idx,
  output logic sel_ccfg_dat,
  output logic sel_tmr,
  output logic sel_kbd,
  output logic sel_portb,
  output logic sel_rtc_addr,
  output logic sel_rtc_data
);

  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // Every compare uses all 16 bits so no alias responds
  always_comb begin
    sel_dma1 = in_range(addr, scd_pkg::IO_DMA1_LO,
                        scd_pkg::IO_DMA1_HI);
    sel_pic1 = in_range(addr, scd_pkg::IO_PIC1_LO, scd_pkg::IO_PIC1_HI);
    sel_pcfg_idx = (addr == scd_pkg::IO_PCFG_IDX);
    sel_pcfg_dat = (addr == scd_pkg::IO_PCFG_DAT);
    sel_ccfg_idx = in_range(addr, scd_pkg::IO_CCFG_IDX,
                            scd_pkg::IO_CCFG_IDX_HI);
    sel_ccfg_dat = in_range(addr, scd_pkg::IO_CCFG_DAT,
                            scd_pkg::IO_CCFG_DAT_HI);
    sel_tmr = in_range(addr, scd_pkg::IO_TMR_LO, scd_pkg::IO_TMR_HI);
    sel_kbd = (addr == scd_pkg::IO_KBD_DATA) ||
              (addr == scd_pkg::IO_KBD_CMD);
    sel_portb = (addr == scd_pkg::IO_PORTB);
    sel_rtc_addr = (addr == scd_pkg::IO_RTC_ADDR);
    sel_rtc_data = (addr == scd_pkg::IO_RTC_DATA);
  end

endmodule : scd_io_decode

// file: core/scd_strap_latch.sv
// Purpose: Strap sampling latch, open while power-good is low
// Assumes: Pins already synchronised by the caller
// Notes: Holds from the power-good rise until the next fall
`timescale 1ns/1ps
module scd_strap_latch (
  // Clock
  input wire logic clk,
  // Control
  input wire logic power_good,
  input wire logic [scd_pkg::STRAP_W-1:0] pins,
  // Captured value
  output logic [scd_pkg::STRAP_W-1:0] straps
);

  logic [scd_pkg::STRAP_W-1:0] straps_q;

  // Transparent while power-good is low; frozen on the rise
  always_ff @(posedge clk) begin
    if (!power_good) begin
      straps_q <= pins;
    end
  end

  assign straps = straps_q;

  a_latch_hold: assert property (@(posedge clk)
    power_good && $past(power_good) |-> $stable(straps_q))
    else $error("strap latch changed while power-good high");

endmodule : scd_strap_latch

// file: core/scd_top.sv
// Contract
// - Capture strap pins while power-good low
// - Straps readable in power-up options register
// - Re-drive straps onto pins in standby
// - Strap1 low enables clock; copied to flag
// - Mouse pins become selects when both disabled
// - Strap2 low enables keyboard controller
// - Strap3 selects 8 or 16-bit BIOS
// - Strap4 selects two or seven DMA channels
// - Strap5 muxes IRQs, repurposes six IRQ pins
// - Strap6 IDE or parity, only with strap5
// - Strap7 refresh indicator or user select one
// - Strap8 splits serial modem pins six/two
// - Strap9 IRQ10 or serial clock input
// - Straps 10,11 captured, software-visible only
// - Drive two mux select clocks when needed
// - Full 16-bit I/O address compare
// - Decode config index/data pairs 022-027
// - Decode DMA, PIC, timer, keyboard ranges
// - Clock address strobe on write 0x70
// - Clock data strobe on access 0x71
// - Speaker equals port B bit1 AND timer2
// - SMI request raises SMI or restarts timer
//
// Purpose: Strap configuration loader and fixed I/O glue
// Assumes: CLOCK 40 MHz; I/O cycle qualified by IO_RD/IO_WR strobes
// Notes: Strap pins use three-flop sampling; standby re-drives them
`timescale 1ns/1ps
module scd_top (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic POWER_GOOD_IN,
  // Strap pins, two-way
  input wire logic [11:0] STRAP_PINS_IN,
  output logic [11:0] STRAP_PINS_OUT,
  output logic STRAP_PINS_OE_N,
  input wire logic STANDBY,
  // Host I/O cycle
  input wire logic [15:0] IO_ADDR,
  input wire logic IO_RD,
  input wire logic IO_WR,
  input wire logic IO_WORD,
  input wire logic [15:0] IO_WDATA,
  output logic [15:0] IO_RDATA,
  output logic IO_HIT,
  // Peripheral selects
  output logic SEL_DMA1,
  output logic SEL_PIC1,
  output logic SEL_TIMER,
  output logic SEL_KBD,
  output logic SEL_PORTB,
  output logic KEYBOARD_CHIP_SELECT_N,
  output logic USER_SELECT0_N,
  output logic USER_SELECT1_N,
  input wire logic USER_SELECT0_REQ,
  input wire logic USER_SELECT1_REQ,
  // External clock strobes, mouse pins share them
  output logic EXT_CLOCK_ADDR_STROBE,
  output logic EXT_CLOCK_DATA_STROBE,
  output logic POINTER_PINS_ACTIVE,
  // Mode outputs
  output logic INT_CLOCK_EN,
  output logic INT_KBD_EN,
  output logic BIOS_16BIT,
  output logic DMA_SEVEN_CH,
  output logic IRQ34_PINS_EN,
  output logic IRQ_MUXED,
  output logic IDE_EN,
  output logic PARITY_EN,
  output logic REFRESH_PIN_EN,
  output logic SERIAL_SPLIT,
  output logic SERIAL_CLOCK_IN_EN,
  output logic MUX_SELECT_HI,
  output logic MUX_SELECT_LO,
  // Speaker
  input wire logic [7:0] PORTB_VALUE,
  input wire logic TIMER2_OUT,
  output logic SPEAKER_OUT,
  // SMI
  input wire logic SMI_REQUEST_IN_N,
  output logic SMI_OUT,
  output logic ACTIVITY_RESTART
);

  // ----------------------------------------------------------------
  // Input sampling
  // ----------------------------------------------------------------
  logic [11:0] strap_s1_q, strap_s2_q, strap_s3_q;
  logic [11:0] strap_clean_q;
  logic [2:0] pg_q;
  logic pg_clean_q;
  logic [2:0] smi_q;
  logic smi_clean_q;
  logic [11:0] straps;

  // A pin change counts once the second and third stage agree
  always_ff @(posedge CLOCK) begin
    strap_s1_q <= STRAP_PINS_IN;
    strap_s2_q <= strap_s1_q;
    strap_s3_q <= strap_s2_q;
    if (strap_s2_q == strap_s3_q) begin
      strap_clean_q <= strap_s3_q;
    end
  end

  always_ff @(posedge CLOCK) begin
    pg_q <= {pg_q[1:0], POWER_GOOD_IN};
    if (pg_q[1] == pg_q[2]) begin
      pg_clean_q <= pg_q[2];
    end
  end

  always_ff @(posedge CLOCK) begin
    smi_q <= {smi_q[1:0], ~SMI_REQUEST_IN_N};
    if (smi_q[1] == smi_q[2]) begin
      smi_clean_q <= smi_q[2];
    end
  end

  // Power-good acts as the strap reset; RST does not touch it
  scd_strap_latch u_latch (
    .clk(CLOCK),
    .power_good(pg_clean_q),
    .pins(strap_clean_q),
    .straps(straps)
  );

  // ----------------------------------------------------------------
  // Mode decode from straps
  // ----------------------------------------------------------------
  logic rtc_en, kbd_en, muxed, dma7;
  assign rtc_en = ~straps[scd_pkg::ST_RTC_DIS];
  assign kbd_en = ~straps[scd_pkg::ST_KBD_DIS];
  assign dma7 = straps[scd_pkg::ST_DMA7];
  assign muxed = straps[scd_pkg::ST_IRQMUX];

  always_ff @(posedge CLOCK) begin
    INT_CLOCK_EN <= rtc_en;
    INT_KBD_EN <= kbd_en;
    BIOS_16BIT <= straps[scd_pkg::ST_BIOS16];
    DMA_SEVEN_CH <= dma7;
    IRQ34_PINS_EN <= ~dma7;
    IRQ_MUXED <= muxed;
    IDE_EN <= muxed & ~straps[scd_pkg::ST_PARITY];
    PARITY_EN <= muxed & straps[scd_pkg::ST_PARITY];
    REFRESH_PIN_EN <= ~straps[scd_pkg::ST_USR1];
    SERIAL_SPLIT <= straps[scd_pkg::ST_COMSPLIT];
    SERIAL_CLOCK_IN_EN <= straps[scd_pkg::ST_SER_CLK];
  end

  // ----------------------------------------------------------------
  // Strap re-drive in standby
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      STRAP_PINS_OE_N <= 1'b1;
      STRAP_PINS_OUT <= 12'h000;
    end else begin
      STRAP_PINS_OE_N <= ~(STANDBY & pg_clean_q);
      STRAP_PINS_OUT <= straps;
    end
  end

  // ----------------------------------------------------------------
  // Mux select clocks
  // ----------------------------------------------------------------
  logic [1:0] muxsel_q;
  logic [$clog2(scd_pkg::MUXSEL_DIV)-1:0] div_q;
  logic mux_need;
  assign mux_need = muxed | dma7;

  // Two-bit count walks the external mux through all four inputs
  always_ff @(posedge CLOCK) begin
    if (RST || !mux_need) begin
      div_q <= '0;
      muxsel_q <= 2'h0;
    end else begin
      div_q <= div_q + 1'b1;
      if (div_q == '1) begin
        muxsel_q <= muxsel_q + 2'h1;
      end
    end
  end

  assign MUX_SELECT_HI = muxsel_q[1];
  assign MUX_SELECT_LO = muxsel_q[0];

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic s_dma1, s_pic1, s_pidx, s_pdat, s_cidx, s_cdat;
  logic s_tmr, s_kbd, s_portb, s_rtca, s_rtcd;

  scd_io_decode u_dec (
    .addr(IO_ADDR),
    .sel_dma1(s_dma1),
    .sel_pic1(s_pic1),
    .sel_pcfg_idx(s_pidx),
    .sel_pcfg_dat(s_pdat),
    .sel_ccfg_idx(s_cidx),
    .sel_ccfg_dat(s_cdat),
    .sel_tmr(s_tmr),
    .sel_kbd(s_kbd),
    .sel_portb(s_portb),
    .sel_rtc_addr(s_rtca),
    .sel_rtc_data(s_rtcd)
  );

  logic io_cyc;
  assign io_cyc = IO_RD | IO_WR;
  assign SEL_DMA1 = s_dma1 & io_cyc;
  assign SEL_PIC1 = s_pic1 & io_cyc;
  assign SEL_TIMER = s_tmr & io_cyc;
  assign SEL_PORTB = s_portb & io_cyc;
  assign IO_HIT = io_cyc & (s_pidx | s_pdat | s_cidx | s_cdat);

  // ----------------------------------------------------------------
  // Shared mouse / strobe / select pins
  // ----------------------------------------------------------------
  logic kbd_cs;
  assign kbd_cs = s_kbd & io_cyc;
  assign EXT_CLOCK_ADDR_STROBE = ~rtc_en & IO_WR & ~IO_WORD
                                 & s_rtca;
  assign EXT_CLOCK_DATA_STROBE = ~rtc_en & io_cyc & ~IO_WORD
                                 & s_rtcd;
  // Internal clock off: pointer lines only if keyboard still on
  assign POINTER_PINS_ACTIVE = kbd_en & ~rtc_en;
  assign SEL_KBD = kbd_cs & kbd_en;
  assign KEYBOARD_CHIP_SELECT_N = ~(kbd_cs & ~kbd_en);
  assign USER_SELECT0_N = ~(USER_SELECT0_REQ & ~kbd_en
                            & ~rtc_en);
  assign USER_SELECT1_N = ~(USER_SELECT1_REQ
                            & straps[scd_pkg::ST_USR1]);

  // ----------------------------------------------------------------
  // Speaker
  // ----------------------------------------------------------------
  assign SPEAKER_OUT = PORTB_VALUE[scd_pkg::PB_SPK_BIT]
                       & TIMER2_OUT;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0] pcfg_data_q;
  logic pcfg_open_q;
  logic [scd_pkg::CIDX_W-1:0] cidx_q;
  logic [3:0] bios_rev_q;
  logic smi_mode_q, smi_stat_q;
  logic extclk_q;
  logic smi_set;
  logic wr_cdat;

  assign wr_cdat = IO_WR & s_cdat;
  assign smi_set = smi_clean_q & ~smi_mode_q;

  // Data port only answers after index 0x01; any data write closes it
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pcfg_open_q <= 1'b0;
      pcfg_data_q <= scd_pkg::PCFG_RESET;
    end else if (IO_WR && s_pidx) begin
      pcfg_open_q <= (IO_WDATA[7:0] == scd_pkg::PCFG_IDX_VALID);
    end else if (IO_WR && s_pdat) begin
      if (pcfg_open_q) begin
        pcfg_data_q <= IO_WDATA[7:0];
      end
      pcfg_open_q <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      cidx_q <= '0;
    end else if (IO_WR && s_cidx) begin
      cidx_q <= IO_WDATA[scd_pkg::CIDX_W-1:0];
    end
  end

  // A byte write to either data half updates the full word
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      bios_rev_q <= 4'h0;
      smi_mode_q <= 1'b0;
    end else if (wr_cdat && cidx_q == scd_pkg::CIDX_ID) begin
      bios_rev_q <= IO_WDATA[3:0];
    end else if (wr_cdat && cidx_q == scd_pkg::CIDX_SMI) begin
      smi_mode_q <= IO_WDATA[scd_pkg::SMI_MODE_BIT];
    end
  end

  // External-clock flag loads from strap 1 each power-good low
  always_ff @(posedge CLOCK) begin
    if (!pg_clean_q) begin
      extclk_q <= straps[scd_pkg::ST_RTC_DIS];
    end else if (wr_cdat && cidx_q == scd_pkg::CIDX_OUTREG) begin
      extclk_q <= IO_WDATA[scd_pkg::OUT_EXTCLK_BIT];
    end
  end

  // ----------------------------------------------------------------
  // SMI request
  // ----------------------------------------------------------------
  // Sampled, so a pulse must span a few clocks; set wins over clear
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      smi_stat_q <= 1'b0;
    end else if (smi_set) begin
      smi_stat_q <= 1'b1;
    end else if (wr_cdat && cidx_q == scd_pkg::CIDX_SMI &&
                 IO_WDATA[scd_pkg::SMI_STAT_BIT]) begin
      smi_stat_q <= 1'b0;
    end
  end

  assign SMI_OUT = smi_stat_q;
  assign ACTIVITY_RESTART = smi_clean_q & smi_mode_q;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    IO_RDATA = 16'h0000;
    if (IO_RD && s_pdat && pcfg_open_q) begin
      IO_RDATA = {8'h00, pcfg_data_q};
    end else if (IO_RD && s_cidx) begin
      IO_RDATA = {10'h000, cidx_q};
    end else if (IO_RD && s_cdat) begin
      if (cidx_q == scd_pkg::CIDX_ID) begin
        IO_RDATA = {scd_pkg::ID_CONST, bios_rev_q};
      end else if (cidx_q == scd_pkg::CIDX_PWRUP) begin
        IO_RDATA = {4'h0, straps};
      end else if (cidx_q == scd_pkg::CIDX_SMI) begin
        IO_RDATA = {14'h0000, smi_stat_q, smi_mode_q};
      end else if (cidx_q == scd_pkg::CIDX_OUTREG) begin
        IO_RDATA = {12'h000, extclk_q, 3'h0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_redrive_value: assert property (@(posedge CLOCK) disable iff (RST)
    !STRAP_PINS_OE_N |-> STRAP_PINS_OUT == $past(straps))
    else $error("standby re-drive differs from straps");
  a_pwrup_read: assert property (@(posedge CLOCK) disable iff (RST)
    IO_RD && s_cdat && cidx_q == scd_pkg::CIDX_PWRUP
    |-> IO_RDATA[11:0] == straps)
    else $error("power-up register mismatch");
  a_strobe_addr: assert property (@(posedge CLOCK) disable iff (RST)
    EXT_CLOCK_ADDR_STROBE |-> IO_WR && IO_ADDR == 16'h0070)
    else $error("address strobe outside write to 0x70");
  a_strobe_data: assert property (@(posedge CLOCK) disable iff (RST)
    EXT_CLOCK_DATA_STROBE |-> io_cyc && IO_ADDR == 16'h0071)
    else $error("data strobe outside access to 0x71");
  a_speaker_and: assert property (@(posedge CLOCK) disable iff (RST)
    SPEAKER_OUT == (PORTB_VALUE[1] && TIMER2_OUT))
    else $error("speaker output wrong");
  a_smi_latch: assert property (@(posedge CLOCK) disable iff (RST)
    smi_set |=> SMI_OUT [*2])
    else $error("SMI request not latched");
  a_mux_idle: assert property (@(posedge CLOCK) disable iff (RST)
    !mux_need ##1 !mux_need |-> !MUX_SELECT_HI && !MUX_SELECT_LO)
    else $error("mux selects run when not needed");
  a_ide_gate: assert property (@(posedge CLOCK) disable iff (RST)
    $past(!muxed) |-> !IDE_EN && !PARITY_EN)
    else $error("IDE or parity without IRQ mux");
  a_kbd_alias: assert property (@(posedge CLOCK) disable iff (RST)
    !KEYBOARD_CHIP_SELECT_N |-> IO_ADDR == 16'h0060
    || IO_ADDR == 16'h0064)
    else $error("keyboard select aliased");

  c_standby: cover property (@(posedge CLOCK) !STRAP_PINS_OE_N);
  c_smi: cover property (@(posedge CLOCK) smi_set);
  c_restart: cover property (@(posedge CLOCK) ACTIVITY_RESTART);
  c_mux: cover property (@(posedge CLOCK) MUX_SELECT_HI && MUX_SELECT_LO);

endmodule : scd_top

// file: shared/scd_pkg.sv
// Purpose: Shared constants for the strap configuration and I/O decode block
// Assumes: 16-bit I/O addresses, byte or word I/O cycles
// Notes: Index values are named here only
package scd_pkg;

  // ----------------------------------------------------------------
  // Fixed I/O addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] IO_DMA1_LO = 16'h0000;
  localparam logic [15:0] IO_DMA1_HI = 16'h000f;
  localparam logic [15:0] IO_PIC1_LO = 16'h0020;
  localparam logic [15:0] IO_PIC1_HI = 16'h0021;
  localparam logic [15:0] IO_PCFG_IDX = 16'h0022;
  localparam logic [15:0] IO_PCFG_DAT = 16'h0023;
  localparam logic [15:0] IO_CCFG_IDX = 16'h0024;
  localparam logic [15:0] IO_CCFG_IDX_HI = 16'h0025;
  localparam logic [15:0] IO_CCFG_DAT = 16'h0026;
  localparam logic [15:0] IO_CCFG_DAT_HI = 16'h0027;
  localparam logic [15:0] IO_TMR_LO = 16'h0040;
  localparam logic [15:0] IO_TMR_HI = 16'h0043;
  localparam logic [15:0] IO_KBD_DATA = 16'h0060;
  localparam logic [15:0] IO_PORTB = 16'h0061;
  localparam logic [15:0] IO_KBD_CMD = 16'h0064;
  localparam logic [15:0] IO_RTC_ADDR = 16'h0070;
  localparam logic [15:0] IO_RTC_DATA = 16'h0071;

  // ----------------------------------------------------------------
  // Indexed registers
  // ----------------------------------------------------------------
  localparam logic [7:0] PCFG_IDX_VALID = 8'h01;
  localparam logic [5:0] CIDX_ID = 6'h00;
  localparam logic [5:0] CIDX_PWRUP = 6'h01;
  localparam logic [5:0] CIDX_SMI = 6'h03;
  localparam logic [5:0] CIDX_OUTREG = 6'h04;
  localparam logic [7:0] PCFG_RESET = 8'h00;
  localparam logic [11:0] ID_CONST = 12'h5a3; // Arbitrary identity value
  localparam int CIDX_W = 6;

  // SMI control register fields
  localparam int SMI_MODE_BIT = 0;
  localparam int SMI_STAT_BIT = 1;
  // Output register field
  localparam int OUT_EXTCLK_BIT = 3;
  // Port B field
  localparam int PB_SPK_BIT = 1;

  // ----------------------------------------------------------------
  // Strap positions
  // ----------------------------------------------------------------
  localparam int STRAP_W = 12;
  localparam int ST_RTC_DIS = 1;
  localparam int ST_KBD_DIS = 2;
  localparam int ST_BIOS16 = 3;
  localparam int ST_DMA7 = 4;
  localparam int ST_IRQMUX = 5;
  localparam int ST_PARITY = 6;
  localparam int ST_USR1 = 7;
  localparam int ST_COMSPLIT = 8;
  localparam int ST_SER_CLK = 9;

  // Mux select clock divider, one phase per step
  localparam int MUXSEL_DIV = 4;

endpackage : scd_pkg

// file: testbench/scd_strap_board.sv
// Purpose: Board strap resistors on the shared strap pins
// Assumes: Resistors are weak, so the device wins whenever it drives
// Notes: No pull on these pins; only resistors or the device set the level
`timescale 1ns/1ps
module scd_strap_board (
  // Resistor pattern
  input wire logic [11:0] strap_cfg,
  // Device side
  input wire logic [11:0] dev_out,
  input wire logic dev_oe_n,
  // Wire level
  output logic [11:0] pins
);
  // Standby drive overrides the resistors and stops their current
  assign pins = dev_oe_n ? strap_cfg : dev_out;
endmodule : scd_strap_board

// file: testbench/scd_top_bench.sv
// Purpose: Self-checking bench for strap capture and fixed I/O glue
// Assumes: Inputs change on the falling edge, I/O cycle results taken on the rise
// Notes: User select requests held high apart from the idle check in each power-up pass
`timescale 1ns/1ps
module scd_top_bench;
  logic clk, rst, pg, stby, rd, wr, word, t2, smi_n, u0r, u1r, oe_n, hit, h;
  logic [11:0] cfg, pins, pout;
  logic [15:0] addr, wdata, rdata, d;
  logic [7:0] pb;
  logic [6:0] sv;
  logic sdma, spic, stmr, skbd, spb, kcs_n, u0_n, u1_n, as, ds, ptr;
  logic ice, ike, b16, d7, i34, im, ide, par, rfe, ss, sce, mh, ml, spk;
  logic smi, act, kc;
  logic [1:0] seen;
  int num_errors = 0;
  int n_checks = 0;
  logic [11:0] pat [3] = '{12'h000, 12'hffe, 12'h0c2};
  logic [15:0] ta [15] = '{16'h0000, 16'h000f, 16'h0010, 16'h0021,
    16'h0043, 16'h0044, 16'h1040, 16'h0064, 16'h0061, 16'h0070, 16'h0070,
    16'h0071, 16'h0071, 16'h1071, 16'h0070};
  logic [2:0] tc [15] = '{3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4,
    3'h4, 3'h2, 3'h3, 3'h4, 3'h2, 3'h4, 3'h4};
  logic [6:0] te [15] = '{7'h40, 7'h40, 7'h00, 7'h20, 7'h10, 7'h00, 7'h00,
    7'h08, 7'h04, 7'h02, 7'h00, 7'h01, 7'h01, 7'h00, 7'h00};

  scd_strap_board i_board (.strap_cfg(cfg), .dev_out(pout),
    .dev_oe_n(oe_n), .pins(pins));

  scd_top i_dut (.CLOCK(clk), .RST(rst), .POWER_GOOD_IN(pg),
    .STRAP_PINS_IN(pins), .STRAP_PINS_OUT(pout), .STRAP_PINS_OE_N(oe_n),
    .STANDBY(stby), .IO_ADDR(addr), .IO_RD(rd), .IO_WR(wr), .IO_WORD(word),
    .IO_WDATA(wdata), .IO_RDATA(rdata), .IO_HIT(hit), .SEL_DMA1(sdma),
    .SEL_PIC1(spic), .SEL_TIMER(stmr), .SEL_KBD(skbd), .SEL_PORTB(spb),
    .KEYBOARD_CHIP_SELECT_N(kcs_n), .USER_SELECT0_N(u0_n),
    .USER_SELECT1_N(u1_n), .USER_SELECT0_REQ(u0r), .USER_SELECT1_REQ(u1r),
    .EXT_CLOCK_ADDR_STROBE(as), .EXT_CLOCK_DATA_STROBE(ds),
    .POINTER_PINS_ACTIVE(ptr), .INT_CLOCK_EN(ice), .INT_KBD_EN(ike),
    .BIOS_16BIT(b16), .DMA_SEVEN_CH(d7), .IRQ34_PINS_EN(i34),
    .IRQ_MUXED(im), .IDE_EN(ide), .PARITY_EN(par), .REFRESH_PIN_EN(rfe),
    .SERIAL_SPLIT(ss), .SERIAL_CLOCK_IN_EN(sce), .MUX_SELECT_HI(mh),
    .MUX_SELECT_LO(ml), .PORTB_VALUE(pb), .TIMER2_OUT(t2),
    .SPEAKER_OUT(spk), .SMI_REQUEST_IN_N(smi_n), .SMI_OUT(smi),
    .ACTIVITY_RESTART(act));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string n, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // One I/O cycle: c is {read, write, word}; held one clock, then released
  task automatic cyc(input logic [15:0] a, input logic [2:0] c,
                     input logic [15:0] v);
    @(negedge clk);
    addr = a;
    {rd, wr, word} = c;
    wdata = v;
    @(posedge clk);
    d = rdata;
    h = hit;
    kc = kcs_n;
    sv = {sdma, spic, stmr, skbd, spb, as, ds};
    @(negedge clk);
    rd = 1'b0;
    wr = 1'b0;
  endtask : cyc

  task automatic power_up(input logic [11:0] s);
    @(negedge clk);
    pg = 1'b0;
    cfg = s;
    repeat (10) @(negedge clk);
    pg = 1'b1;
    repeat (8) @(negedge clk);
  endtask : power_up

  function automatic logic [15:0] modes(input logic [11:0] s);
    return {2'h0, ~s[1], ~s[2], s[3], s[4], ~s[4], s[5], s[5] & ~s[6],
      s[5] & s[6], ~s[7], s[8], s[9], ~(s[1] & s[2]), ~s[7], s[1] & ~s[2]};
  endfunction : modes

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    {rst, pg, stby, rd, wr, word, t2, smi_n, u0r, u1r} = 10'b1000000111;
    cfg = 12'h000;
    addr = 16'h0000;
    wdata = 16'h0000;
    pb = 8'h00;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    foreach (pat[i]) begin
      power_up(pat[i]);
      chk("modes", modes(pat[i]), {2'h0, ice, ike, b16, d7, i34, im, ide,
        par, rfe, ss, sce, u0_n, u1_n, ptr});
      // Mode relation above also
      {u0r, u1r} = 2'b00;
      #1;
      chk("user idle", 16'h0003, {14'h0, u0_n, u1_n});
      @(negedge clk);
      {u0r, u1r} = 2'b11;
      // Both select clocks are seen high within 16 clocks only when needed
      seen = 2'h0;
      repeat (16) begin
        @(negedge clk);
        seen = seen | {mh, ml};
      end
      chk("mux sel", {14'h0, {2{pat[i][4] | pat[i][5]}}},
        {14'h0, seen});
      cyc(16'h0060, 3'h4, 16'h0000);
      chk("kbd cs", {14'h0, {2{~pat[i][2]}}}, {14'h0, kc, sv[3]});
      cyc(16'h0024, 3'h3, 16'h0001);
      cyc(16'h0026, 3'h5, 16'h0000);
      chk("straps", {4'h0, pat[i]}, d);
      // Pins move after power good; the latch must not follow
      cfg = ~pat[i];
      repeat (8) @(negedge clk);
      cyc(16'h0026, 3'h5, 16'h0000);
      chk("held", {4'h0, pat[i]}, d);
      cyc(16'h0024, 3'h3, 16'h0004);
      cyc(16'h0026, 3'h5, 16'h0000);
      chk("ext clock flag", {12'h0, pat[i][1], 3'h0}, d);
      stby = 1'b1;
      repeat (3) @(negedge clk);
      chk("drive", {4'h0, pat[i]}, {3'h0, oe_n, pins});
      stby = 1'b0;
    end
    foreach (ta[i]) begin
      cyc(ta[i], tc[i], 16'h0000);
      chk("select", {9'h0, te[i]}, {9'h0, sv});
    end
    cyc(16'h0022, 3'h2, 16'h0001);
    cyc(16'h0023, 3'h2, 16'h005a);
    cyc(16'h0023, 3'h4, 16'h0000);
    chk("pcfg closed", 16'h0000, {8'h0, d[7:0]});
    cyc(16'h0022, 3'h2, 16'h0001);
    cyc(16'h0023, 3'h4, 16'h0000);
    chk("pcfg data", 16'h005a, {8'h0, d[7:0]});
    chk("hit", 16'h0001, {15'h0, h});
    cyc(16'h0024, 3'h3, 16'h0000);
    cyc(16'h0026, 3'h5, 16'h0000);
    chk("id reset", {scd_pkg::ID_CONST, 4'h0}, d);
    // A single byte to the upper data address writes the whole word
    cyc(16'h0027, 3'h2, 16'hfff5);
    cyc(16'h0026, 3'h5, 16'h0000);
    chk("id", {scd_pkg::ID_CONST, 4'h5}, d);
    cyc(16'h0024, 3'h3, 16'h0002);
    cyc(16'h0026, 3'h5, 16'h0000);
    chk("unused index", 16'h0000, d);
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      pb = (k[1] == 1'b1) ? 8'h02 : 8'hfd;
      t2 = k[0];
      #1;
      chk("speaker", {15'h0, k[1] & k[0]}, {15'h0, spk});
    end
    cyc(16'h0024, 3'h3, 16'h0003);
    @(negedge clk);
    smi_n = 1'b0;
    repeat (6) @(negedge clk);
    smi_n = 1'b1;
    repeat (8) @(negedge clk);
    chk("smi set", 16'h0001, {15'h0, smi});
    cyc(16'h0026, 3'h3, 16'h0002);
    chk("smi clear", 16'h0000, {15'h0, smi});
    cyc(16'h0026, 3'h3, 16'h0001);
    @(negedge clk);
    smi_n = 1'b0;
    repeat (6) @(negedge clk);
    chk("restart", 16'h0002, {14'h0, act, smi});
    smi_n = 1'b1;
    give_verdict();
  end

  // Whole run is under two thousand clocks; this allows ten times that
  initial begin
    #500000;
    num_errors++;
    give_verdict();
  end
endmodule : scd_top_bench
